// [src/mjpf_top.sv]
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "mjpf_regs.svh"

module mjpf_top #(
    parameter int SPEED_W = 24,
    parameter int DIST_W  = 24
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gp_input_zero,
    input  wire logic        gp_input_one,
    input  wire logic        gp_input_two_plus_jog,
    input  wire logic        gp_input_three_minus_jog,
    input  wire logic        stop_factor_present,
    input  wire logic        watchdog_level,
    input  wire logic        net_reset_req,
    output logic             gp_output_zero,
    output logic             gp_output_one,
    output logic             gp_output_two_moving,
    output logic             gp_output_three_watchdog,
    output logic             encoder_zero_sensor,
    output logic             stop_signal,
    output logic             plus_stop_sensor,
    output logic             minus_stop_sensor,
    output logic             step_pulse,
    output logic             step_dir_minus
);
    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    mjpf_jog_if #(.SPEED_W(SPEED_W)) jog ();

    mjpf_pkg::mjpf_state_e state_reg;
    logic [31:0]           ctrl_reg;
    logic [DIST_W-1:0]     dist_reg;
    logic [SPEED_W-1:0]    low_reg;
    logic [SPEED_W-1:0]    upper_reg;
    logic [DIST_W-1:0]     target_reg;
    logic [DIST_W-1:0]     remain_reg;
    logic                  soft_rst_reg;
    logic                  dir_reg;
    logic                  step_reg;
    logic                  apb_wr;
    logic                  apb_rd;
    logic                  manual_en;
    logic                  single_mode;
    logic                  start_ok;
    logic                  one_active;
    logic [1:0]            jog_fs;
    logic [31:0]           rd_word;
    logic                  rd_hit;

    // Writes land at the edge that sees pready high; reads are decoded one edge earlier, while pready is still low.
    assign apb_wr = psel & penable & pready & pwrite;
    assign apb_rd = psel & penable & ~pready;

    // Jog pins act only under the manual selections.
    assign jog_fs      = ctrl_reg[`MJPF_CTRL_JOG_FS_MSB:`MJPF_CTRL_JOG_FS_LSB];
    assign manual_en   = (jog_fs == mjpf_pkg::MJPF_JOG_CONT) | (jog_fs == mjpf_pkg::MJPF_JOG_SINGLE);
    assign single_mode = (jog_fs == mjpf_pkg::MJPF_JOG_SINGLE);
    assign one_active  = jog.plus_lvl ^ jog.minus_lvl;
    // A start needs no stop factor and a distance within the upper speed.
    assign start_ok    = manual_en & one_active & ~stop_factor_present
                         & (32'(dist_reg) <= 32'(upper_reg));

    // Step rate follows the lower speed while moving.
    assign jog.run   = (state_reg != mjpf_pkg::MJPF_IDLE);
    assign jog.speed = low_reg;

    // -------------------------------------------------------------------------
    // Submodules
    // -------------------------------------------------------------------------
    mjpf_jog_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .plus_in  (gp_input_two_plus_jog),
        .minus_in (gp_input_three_minus_jog),
        .jog      (jog.sync_mp)
    );

    mjpf_rate_gen #(.SPEED_W(SPEED_W)) u_rate (
        .pclk    (pclk),
        .presetn (presetn),
        .rate    (jog.rate_mp)
    );

    // -------------------------------------------------------------------------
    // Remote reset
    // -------------------------------------------------------------------------
    // A network reset request is registered, then restores the register file and jog state one cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= net_reset_req;
        end
    end

    // -------------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------------
    // Software-writable control word and pattern entry 31.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `MJPF_RST_CTRL;
            target_reg <= `MJPF_RST_TARGET;
            dist_reg   <= `MJPF_RST_DISTANCE;
            low_reg    <= `MJPF_RST_LOW_SPEED;
            upper_reg  <= `MJPF_RST_UPPER_SPEED;
        end else if (soft_rst_reg) begin
            ctrl_reg   <= `MJPF_RST_CTRL;
            target_reg <= `MJPF_RST_TARGET;
            dist_reg   <= `MJPF_RST_DISTANCE;
            low_reg    <= `MJPF_RST_LOW_SPEED;
            upper_reg  <= `MJPF_RST_UPPER_SPEED;
        end else if (apb_wr) begin
            case (paddr)
                `MJPF_OFF_CTRL:        ctrl_reg   <= pwdata & 32'h0000_0F3F;
                `MJPF_OFF_TARGET:      target_reg <= pwdata[DIST_W-1:0];
                `MJPF_OFF_DISTANCE:    dist_reg   <= pwdata[DIST_W-1:0];
                `MJPF_OFF_LOW_SPEED:   low_reg    <= pwdata[SPEED_W-1:0];
                `MJPF_OFF_UPPER_SPEED: upper_reg  <= pwdata[SPEED_W-1:0];
                default: ;
            endcase
        end
    end

    // Read multiplexer; status shows pins, motion and direction.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            `MJPF_OFF_CTRL:        rd_word = ctrl_reg;
            `MJPF_OFF_STATUS:      rd_word = {25'h000_0000, state_reg == mjpf_pkg::MJPF_BURST, dir_reg,
                                              jog.run, gp_input_three_minus_jog, gp_input_two_plus_jog,
                                              gp_input_one, gp_input_zero};
            `MJPF_OFF_TARGET:      rd_word = 32'(target_reg);
            `MJPF_OFF_DISTANCE:    rd_word = 32'(dist_reg);
            `MJPF_OFF_LOW_SPEED:   rd_word = 32'(low_reg);
            `MJPF_OFF_UPPER_SPEED: rd_word = 32'(upper_reg);
            default:               rd_hit  = 1'b0;
        endcase
    end

    // APB answer: one wait cycle, then pready with data or error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            pslverr <= ~rd_hit;
            prdata  <= (apb_rd & ~pwrite) ? rd_word : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Manual jog state machine
    // -------------------------------------------------------------------------
    // Idle waits for a valid request; bursts ignore new edges until done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= mjpf_pkg::MJPF_IDLE;
            dir_reg    <= 1'b0;
            remain_reg <= '0;
        end else if (soft_rst_reg) begin
            state_reg  <= mjpf_pkg::MJPF_IDLE;
            dir_reg    <= 1'b0;
            remain_reg <= '0;
        end else begin
            case (state_reg)
                mjpf_pkg::MJPF_IDLE: begin
                    if (start_ok && !single_mode) begin
                        state_reg <= mjpf_pkg::MJPF_CONT;
                        dir_reg   <= jog.minus_lvl;
                    end else if (start_ok && (jog.plus_rise || jog.minus_rise) && dist_reg != '0) begin
                        state_reg  <= mjpf_pkg::MJPF_BURST;
                        dir_reg    <= jog.minus_lvl;
                        remain_reg <= dist_reg;
                    end
                end
                mjpf_pkg::MJPF_CONT: begin
                    if (!manual_en || single_mode || !one_active || stop_factor_present
                        || (jog.minus_lvl != dir_reg)) begin
                        state_reg <= mjpf_pkg::MJPF_IDLE;
                    end
                end
                mjpf_pkg::MJPF_BURST: begin
                    if (stop_factor_present) begin
                        state_reg <= mjpf_pkg::MJPF_IDLE;
                    end else if (jog.tick) begin
                        remain_reg <= remain_reg - 1'b1;
                        if (remain_reg == DIST_W'(1)) begin
                            state_reg <= mjpf_pkg::MJPF_IDLE;
                        end
                    end
                end
                default: state_reg <= mjpf_pkg::MJPF_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Step output
    // -------------------------------------------------------------------------
    // One-cycle step pulse per rate tick while moving.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_pulse     <= 1'b0;
            step_dir_minus <= 1'b0;
            step_reg       <= 1'b0;
        end else begin
            step_reg       <= jog.tick & jog.run & ~soft_rst_reg;
            step_pulse     <= jog.tick & jog.run & ~soft_rst_reg;
            step_dir_minus <= dir_reg;
        end
    end

    // -------------------------------------------------------------------------
    // Shared pin routing
    // -------------------------------------------------------------------------
    // Alternate functions take the pins; otherwise they stay general purpose.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp_output_zero           <= 1'b0;
            gp_output_one            <= 1'b0;
            gp_output_two_moving     <= 1'b0;
            gp_output_three_watchdog <= 1'b0;
            encoder_zero_sensor      <= 1'b0;
            stop_signal              <= 1'b0;
            plus_stop_sensor         <= 1'b0;
            minus_stop_sensor        <= 1'b0;
        end else begin
            gp_output_zero           <= ctrl_reg[`MJPF_CTRL_GPO_LSB];
            gp_output_one            <= ctrl_reg[`MJPF_CTRL_GPO_LSB + 1];
            gp_output_two_moving     <= ctrl_reg[`MJPF_CTRL_MOV_FS] ? jog.run
                                        : ctrl_reg[`MJPF_CTRL_GPO_LSB + 2];
            gp_output_three_watchdog <= ctrl_reg[`MJPF_CTRL_WDG_FS] ? watchdog_level
                                        : ctrl_reg[`MJPF_CTRL_GPO_MSB];
            encoder_zero_sensor      <= ctrl_reg[`MJPF_CTRL_EZ_FS] & gp_input_zero;
            stop_signal              <= ctrl_reg[`MJPF_CTRL_STOP_FS] & gp_input_one;
            plus_stop_sensor         <= (jog_fs == mjpf_pkg::MJPF_JOG_STOP) & gp_input_two_plus_jog;
            minus_stop_sensor        <= (jog_fs == mjpf_pkg::MJPF_JOG_STOP) & gp_input_three_minus_jog;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_both_active_hold: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && jog.plus_lvl && jog.minus_lvl)
        |=> state_reg == mjpf_pkg::MJPF_IDLE)
        else $error("jog started with both inputs active");
    a_disabled_no_start: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && !manual_en) |=> state_reg == mjpf_pkg::MJPF_IDLE)
        else $error("jog started while manual not selected");
    a_stop_factor_block: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && stop_factor_present) |=> state_reg == mjpf_pkg::MJPF_IDLE)
        else $error("jog started with a stop factor present");
    a_dist_limit_block: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && 32'(dist_reg) > 32'(upper_reg))
        |=> state_reg == mjpf_pkg::MJPF_IDLE)
        else $error("jog started with distance above upper speed");
    a_start_direction: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && !soft_rst_reg ##1 state_reg != mjpf_pkg::MJPF_IDLE)
        |-> dir_reg == $past(jog.minus_lvl))
        else $error("jog direction does not follow the active input");
    a_cont_holds: assert property (
        (state_reg == mjpf_pkg::MJPF_CONT && !soft_rst_reg && !single_mode && manual_en && one_active
         && !stop_factor_present && jog.minus_lvl == dir_reg) |=> state_reg == mjpf_pkg::MJPF_CONT)
        else $error("continue mode stopped while input active");
    a_burst_load: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE ##1 state_reg == mjpf_pkg::MJPF_BURST)
        |-> remain_reg == $past(dist_reg))
        else $error("burst length differs from stored distance");
    a_single_mode_only: assert property (
        (state_reg == mjpf_pkg::MJPF_IDLE && !single_mode) |=> state_reg != mjpf_pkg::MJPF_BURST)
        else $error("burst started outside single mode");
    a_moving_output: assert property (
        (ctrl_reg[`MJPF_CTRL_MOV_FS] && !soft_rst_reg) |=> gp_output_two_moving == $past(jog.run))
        else $error("moving output does not show axis motion");
    a_reset_defaults: assert property (
        soft_rst_reg |=> (dist_reg == `MJPF_RST_DISTANCE && low_reg == `MJPF_RST_LOW_SPEED
                          && upper_reg == `MJPF_RST_UPPER_SPEED && ctrl_reg == `MJPF_RST_CTRL))
        else $error("remote reset left non-default entry 31 values");
    a_step_when_moving: assert property (
        step_reg |-> $past(jog.run) && $past(jog.tick))
        else $error("step pulse without a rate tick while moving");
    a_burst_ignores_edges: assert property (
        (state_reg == mjpf_pkg::MJPF_BURST && !jog.tick && !stop_factor_present && !soft_rst_reg)
        |=> (state_reg == mjpf_pkg::MJPF_BURST && remain_reg == $past(remain_reg)))
        else $error("burst restarted or changed length without a tick");
    a_write_lands: assert property (
        (apb_wr && paddr == `MJPF_OFF_DISTANCE && !soft_rst_reg)
        |=> dist_reg == $past(pwdata[DIST_W-1:0]))
        else $error("distance write did not land");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_stop_routing: assert property (
        plus_stop_sensor == $past(jog_fs == mjpf_pkg::MJPF_JOG_STOP && gp_input_two_plus_jog))
        else $error("plus stop sensor routing wrong");

    c_cont_entered:  cover property (state_reg == mjpf_pkg::MJPF_IDLE ##1 state_reg == mjpf_pkg::MJPF_CONT);
    c_burst_done:    cover property (state_reg == mjpf_pkg::MJPF_BURST ##1 state_reg == mjpf_pkg::MJPF_IDLE);
    c_dist_refused:  cover property (manual_en && one_active && 32'(dist_reg) > 32'(upper_reg));
    c_apb_write:     cover property (apb_wr && paddr == `MJPF_OFF_DISTANCE);
    c_net_reset:     cover property (soft_rst_reg);
endmodule

// [src/mjpf_regs.svh]
`ifndef MJPF_REGS_SVH
`define MJPF_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// -----------------------------------------------------------------------------
`define MJPF_OFF_CTRL        12'h000
`define MJPF_OFF_STATUS      12'h004
`define MJPF_OFF_LOW_SPEED   12'h008
`define MJPF_OFF_DISTANCE    12'h00C
`define MJPF_OFF_UPPER_SPEED 12'h010
`define MJPF_OFF_TARGET      12'h014

// -----------------------------------------------------------------------------
// Control register field positions
// -----------------------------------------------------------------------------
`define MJPF_CTRL_JOG_FS_LSB 0
`define MJPF_CTRL_JOG_FS_MSB 1
`define MJPF_CTRL_STOP_FS    2
`define MJPF_CTRL_EZ_FS      3
`define MJPF_CTRL_MOV_FS     4
`define MJPF_CTRL_WDG_FS     5
`define MJPF_CTRL_GPO_LSB    8
`define MJPF_CTRL_GPO_MSB    11

// -----------------------------------------------------------------------------
// Reset values of pattern entry 31 and of the control word
// -----------------------------------------------------------------------------
`define MJPF_RST_CTRL        32'h0000_0000
`define MJPF_RST_TARGET      24'h00_0000
`define MJPF_RST_DISTANCE    24'd2000
`define MJPF_RST_LOW_SPEED   24'd2000
`define MJPF_RST_UPPER_SPEED 24'd2500

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define MJPF_CLK_HZ          26'd40000000

`endif

// [src/mjpf_pkg.sv]
package mjpf_pkg;

    // Manual jog state, one-hot.
    typedef enum logic [2:0] {
        MJPF_IDLE  = 3'b001,
        MJPF_CONT  = 3'b010,
        MJPF_BURST = 3'b100
    } mjpf_state_e;

    // Function of shared inputs two and three.
    typedef enum logic [1:0] {
        MJPF_JOG_GP     = 2'h0,
        MJPF_JOG_STOP   = 2'h1,
        MJPF_JOG_CONT   = 2'h2,
        MJPF_JOG_SINGLE = 2'h3
    } mjpf_jog_fs_e;

endpackage

// [src/mjpf_jog_if.sv]
`timescale 1ns/1ps
// Carries jog switch levels and edges, and the step rate request and tick.
interface mjpf_jog_if #(parameter int SPEED_W = 24);
    logic               plus_lvl;
    logic               minus_lvl;
    logic               plus_rise;
    logic               minus_rise;
    logic               run;
    logic [SPEED_W-1:0] speed;
    logic               tick;
    modport sync_mp (output plus_lvl, minus_lvl, plus_rise, minus_rise);
    modport rate_mp (input run, speed, output tick);
    modport ctrl_mp (input plus_lvl, minus_lvl, plus_rise, minus_rise, tick, output run, speed);
endinterface

// [src/mjpf_jog_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser and rising-edge detector for the jog switches.
module mjpf_jog_sync (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   plus_in,
    input  wire logic   minus_in,
    mjpf_jog_if.sync_mp jog
);
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;

    // First stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
            prev_reg <= 2'h0;
        end else begin
            meta_reg <= {minus_in, plus_in};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Levels and inactive-to-active edges.
    assign jog.plus_lvl   = sync_reg[0];
    assign jog.minus_lvl  = sync_reg[1];
    assign jog.plus_rise  = sync_reg[0] & ~prev_reg[0];
    assign jog.minus_rise = sync_reg[1] & ~prev_reg[1];
endmodule

// [src/mjpf_rate_gen.sv]
`timescale 1ns/1ps
`include "mjpf_regs.svh"
// Phase accumulator: emits one-cycle ticks at speed pulses per second.
module mjpf_rate_gen #(
    parameter int SPEED_W = 24
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    mjpf_jog_if.rate_mp rate
);
    logic [25:0] acc_reg;
    logic [25:0] acc_sum;
    logic        tick_reg;

    assign acc_sum   = acc_reg + 26'(rate.speed);
    assign rate.tick = tick_reg;

    // Accumulate the rate each cycle and wrap at the clock frequency.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg  <= 26'h000_0000;
            tick_reg <= 1'b0;
        end else if (!rate.run) begin
            acc_reg  <= 26'h000_0000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= `MJPF_CLK_HZ) begin
            acc_reg  <= acc_sum - `MJPF_CLK_HZ;
            tick_reg <= 1'b1;
        end else begin
            acc_reg  <= acc_sum;
            tick_reg <= 1'b0;
        end
    end
endmodule

// [testbench/mjpf_jog_partner.sv]
`timescale 1ns/1ps
// Stands in for the operator switches and the motor driver.
module mjpf_jog_partner (
    input  wire logic pclk,
    input  wire logic step_pulse,
    input  wire logic step_dir_minus,
    output logic      plus_sw,
    output logic      minus_sw
);
    int n_plus;
    int n_minus;

    // Switches start released and no steps are counted yet.
    initial begin
        plus_sw  = 1'b0;
        minus_sw = 1'b0;
        n_plus   = 0;
        n_minus  = 0;
    end

    // Counts every step that the driver sees, split by direction.
    always @(posedge pclk) begin
        if (step_pulse === 1'b1) begin
            if (step_dir_minus === 1'b1) begin
                n_minus++;
            end else begin
                n_plus++;
            end
        end
    end

    // Sets both switch levels; the caller has just passed a clock edge.
    task automatic press(input logic p, input logic m);
        plus_sw  <= p;
        minus_sw <= m;
    endtask

    // Zeroes the step counts before a new jog.
    task automatic clear();
        n_plus  = 0;
        n_minus = 0;
    endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "mjpf_regs.svh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic        gi0, gi1, psw, msw, stopf, wdl, nrst, o0, o1, o2, o3, ez, stp, ps, ms, step, dirm;
    int          n_fail = 0;
    int          compares = 0;
    int          cnt;

    mjpf_top mjpf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gp_input_zero(gi0), .gp_input_one(gi1), .gp_input_two_plus_jog(psw), .gp_input_three_minus_jog(msw),
        .stop_factor_present(stopf), .watchdog_level(wdl), .net_reset_req(nrst), .gp_output_zero(o0),
        .gp_output_one(o1), .gp_output_two_moving(o2), .gp_output_three_watchdog(o3), .encoder_zero_sensor(ez),
        .stop_signal(stp), .plus_stop_sensor(ps), .minus_stop_sensor(ms), .step_pulse(step), .step_dir_minus(dirm));
    mjpf_jog_partner mjpf_jog_partner_inst (.pclk(pclk), .step_pulse(step), .step_dir_minus(dirm),
        .plus_sw(psw), .minus_sw(msw));

    // Free-running 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compares a seen value with the expected one and reports a difference.
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Holds the switches for a number of cycles, then lets the steps settle.
    task automatic jog(input logic p, input logic m, input int hold);
        mjpf_jog_partner_inst.clear();
        @(posedge pclk);
        mjpf_jog_partner_inst.press(p, m);
        repeat (hold) @(posedge pclk);
        mjpf_jog_partner_inst.press(1'b0, 1'b0);
        repeat (30) @(posedge pclk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        stop_test();
    end

    // Main sequence of tests.
    initial begin
        {presetn, psel, penable, pwrite, gi0, gi1, stopf, wdl, nrst} = '0;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MJPF_OFF_CTRL, 32'h0000_0000);
        check("ctrl", rq, 32'h0000_0000);
        apb(1'b0, `MJPF_OFF_DISTANCE, 32'h0000_0000);
        check("distance", rq, 32'h0000_07D0);
        apb(1'b0, `MJPF_OFF_LOW_SPEED, 32'h0000_0000);
        check("low speed", rq, 32'h0000_07D0);
        apb(1'b0, `MJPF_OFF_UPPER_SPEED, 32'h0000_0000);
        check("upper speed", rq, 32'h0000_09C4);
        apb(1'b0, `MJPF_OFF_TARGET, 32'h0000_0000);
        check("target", rq, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped", 32'(rerr), 32'h0000_0001);
        $display("test defaults done");
        apb(1'b1, `MJPF_OFF_LOW_SPEED, 32'h003D_0900);
        apb(1'b1, `MJPF_OFF_DISTANCE, 32'h0000_0005);
        jog(1'b1, 1'b0, 100);
        check("plain mode steps", mjpf_jog_partner_inst.n_plus, 32'h0000_0000);
        apb(1'b1, `MJPF_OFF_CTRL, 32'h0000_0013);
        mjpf_jog_partner_inst.clear();
        mjpf_jog_partner_inst.press(1'b1, 1'b0);
        repeat (20) @(posedge pclk);
        check("moving", 32'(o2), 32'h0000_0001);
        mjpf_jog_partner_inst.press(1'b0, 1'b0);
        // The burst takes about fifty cycles; let it end before the next edge.
        repeat (60) @(posedge pclk);
        jog(1'b1, 1'b0, 120);
        check("burst plus", mjpf_jog_partner_inst.n_plus, 32'h0000_0005);
        check("stopped", 32'(o2), 32'h0000_0000);
        jog(1'b0, 1'b1, 100);
        check("burst minus", mjpf_jog_partner_inst.n_minus, 32'h0000_0005);
        jog(1'b1, 1'b1, 100);
        check("both", mjpf_jog_partner_inst.n_plus + mjpf_jog_partner_inst.n_minus, 32'h0000_0000);
        stopf <= 1'b1;
        jog(1'b1, 1'b0, 100);
        check("stop factor", mjpf_jog_partner_inst.n_plus, 32'h0000_0000);
        stopf <= 1'b0;
        apb(1'b1, `MJPF_OFF_UPPER_SPEED, 32'h0000_0004);
        jog(1'b1, 1'b0, 100);
        check("distance too big", mjpf_jog_partner_inst.n_plus, 32'h0000_0000);
        apb(1'b1, `MJPF_OFF_UPPER_SPEED, 32'h0000_09C4);
        $display("test single done");
        apb(1'b1, `MJPF_OFF_CTRL, 32'h0000_0012);
        jog(1'b0, 1'b1, 100);
        cnt = mjpf_jog_partner_inst.n_minus;
        check("continue rate", 32'(cnt >= 8 && cnt <= 11), 32'h0000_0001);
        repeat (50) @(posedge pclk);
        check("continue halt", mjpf_jog_partner_inst.n_minus, cnt);
        $display("test continue done");
        apb(1'b1, `MJPF_OFF_CTRL, 32'h0000_0A2D);
        gi0 <= 1'b1;
        gi1 <= 1'b1;
        jog(1'b1, 1'b0, 4);
        check("sensor steps", mjpf_jog_partner_inst.n_plus, 32'h0000_0000);
        mjpf_jog_partner_inst.press(1'b1, 1'b0);
        repeat (4) @(posedge pclk);
        check("routing", {ez, stp, ps, ms, o0, o1, o2, o3}, 32'h0000_00E4);
        wdl <= 1'b1;
        repeat (3) @(posedge pclk);
        check("watchdog out", 32'(o3), 32'h0000_0001);
        nrst <= 1'b1;
        @(posedge pclk);
        nrst <= 1'b0;
        repeat (3) @(posedge pclk);
        check("net reset out", 32'(o1), 32'h0000_0000);
        apb(1'b0, `MJPF_OFF_DISTANCE, 32'h0000_0000);
        check("net reset dist", rq, 32'h0000_07D0);
        $display("test routing done");
        stop_test();
    end
endmodule
